// File: logic/pmc_pkg.sv
package pmc_pkg;
  // ==========================================================
  // register indices (byte address is four times the index)
  localparam logic [13:0] IDX_CORE_PWR   = 14'h0087;
  localparam logic [13:0] IDX_PD_POL     = 14'h22f0;
  localparam logic [13:0] IDX_PD_CFG     = 14'h22f1;
  localparam logic [13:0] IDX_STAB_DLY   = 14'h22f4;
  localparam logic [13:0] IDX_IRQ_STATUS = 14'h2300;
  localparam logic [13:0] IDX_IRQ_MASK   = 14'h2301;
  // ==========================================================
  // field positions
  localparam int CP_CLOCK_STOP = 1;
  localparam int CP_IDLE       = 0;
  localparam int PP_POL_A      = 5;
  localparam int PP_POL_B      = 4;
  localparam int PP_START      = 0;
  localparam int PC_AREG_EN    = 7;
  localparam int PC_MON_EN     = 6;
  localparam int PC_AREG_GOOD  = 5;
  localparam int PC_SLEEP_EN   = 4;
  localparam int PC_RC_EN      = 3;
  localparam int PC_BOD        = 2;
  localparam int PC_MODE_LO    = 0;
  localparam int IRQ_ENTRY     = 0;
  localparam int IRQ_WAKE      = 1;
  localparam int IRQ_GOOD      = 2;
  // ==========================================================
  // reset values, widths and timing
  localparam logic [7:0] PD_CFG_RESET   = 8'hc8;
  localparam logic [7:0] STAB_DLY_RESET = 8'h11;
  localparam int         IRQ_BITS       = 3;
  localparam logic [1:0] START_CYCLES   = 2'h2;
  // ==========================================================
  // chip power modes
  localparam logic [1:0] MODE_NORMAL_RUN  = 2'h0;
  localparam logic [1:0] MODE_LIGHT_SLEEP = 2'h1;
  localparam logic [1:0] MODE_DEEP_SLEEP  = 2'h2;
  localparam logic [1:0] MODE_FULL_OFF    = 2'h3;
  typedef enum logic [1:0] {PMC_RUN, PMC_LOWPOWER, PMC_STABILIZE} pmc_state_e;
endpackage : pmc_pkg

// File: logic/pmc_power_mode_control.sv
// Operation
// - writing one to the core clock stop bit stops every processor core clock.
// - the core idle bit stops core clocks but leaves peripheral clocks running.
// - each external interrupt polarity bit selects high-level (1) or low-level (0) recognition.
// - a one written to the entry strobe starts the selected mode and self-clears after 2 cycles.
// - the analog regulator enable bit turns the regulator on when one and resets to one.
// - the regulator monitor enable bit turns the monitor on when one and resets to one.
// - the read-only regulator good flag is high when the monitor is on and the output is good.
// - the sleep counter enable bit runs the sleep timer when one.
// - the rc oscillator enable bit lets the oscillator run and resets to one.
// - the brown-out control bit polarity is a build parameter.
// - mode field 00 is normal run and 01, 10, 11 are the three low-power modes in order.
// - software sets the mode first and the mode begins only when the entry strobe is written.
// - light sleep keeps digital regulator and timer, deep sleep only the timer, full off none.
// - on exit the block waits the programmed stabilization delay before resuming.
// - the core leaves clock stop when a wake interrupt arrives and then continues.
//
// The AHB-Lite slave port was left to the implementer.
module pmc_power_mode_control
  import pmc_pkg::*;
#(
  parameter bit BOD_ONE_ENABLES = 1'b1
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        ce,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        wake_irq,
  input  wire logic        ext_irq_a_pin,
  input  wire logic        ext_irq_b_pin,
  input  wire logic        analog_regulator_output_ok,
  output logic             ext_irq_a_active,
  output logic             ext_irq_b_active,
  output logic             core_clk_en,
  output logic             periph_clk_en,
  output logic             analog_regulator_enable,
  output logic             analog_regulator_monitor_enable,
  output logic             sleep_counter_enable,
  output logic             rc_osc_enable,
  output logic             brownout_detector_enable,
  output logic             digital_regulator_on,
  output logic             main_osc_on,
  output logic             analog_regulator_on,
  output logic             sleep_timer_on,
  output logic             lowpower_active,
  output logic             irq
);

  // ==========================================================
  // bus address phase capture
  logic             wr_pend_q;
  logic [13:0]      wr_idx_q;
  logic [13:0]      rd_idx;
  logic             addr_ok;
  logic             wr_now;
  logic [7:0]       wd;
  logic [1:0]       core_pwr_q;
  logic [1:0]       pol_q;
  logic             start_q;
  logic [1:0]       start_cnt_q;
  logic [7:0]       cfg_q;
  logic             good_q;
  logic [7:0]       dly_q;
  logic [7:0]       dly_cnt_q;
  logic [IRQ_BITS-1:0] status_q;
  logic [IRQ_BITS-1:0] mask_q;
  logic [IRQ_BITS-1:0] event_set;
  logic [1:0]       mode_q;
  logic [1:0]       sel_mode;
  logic [2:0]       sync1_q;
  logic [2:0]       sync2_q;
  logic             good_prev_q;
  logic             wake;
  logic             start_wr;
  pmc_state_e       state_q;

  assign hreadyout = ce;
  assign hresp     = 1'b0;
  assign addr_ok   = hsel && hready && htrans[1];
  assign rd_idx    = haddr[15:2];
  assign wr_now    = ce && wr_pend_q;
  assign wd        = hwdata[7:0];
  assign start_wr  = wr_now && (wr_idx_q == IDX_PD_POL) && wd[PP_START];
  // mode field as programmed, taken on the entry strobe
  assign sel_mode  = cfg_q[PC_MODE_LO +: 2];

  // write intent held from address to data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_idx_q  <= 14'h0000;
    end else if (ce) begin
      wr_pend_q <= addr_ok && hwrite;
      wr_idx_q  <= rd_idx;
    end
  end

  // read data registered at the address phase edge, unmapped reads zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (ce && addr_ok && !hwrite) begin
      unique case (rd_idx)
        IDX_CORE_PWR:   hrdata <= {30'h0, core_pwr_q};
        IDX_PD_POL:     hrdata <= {26'h0, pol_q, 3'h0, start_q};
        IDX_PD_CFG:     hrdata <= {24'h0, cfg_q[7:6], good_q, cfg_q[4:0]};
        IDX_STAB_DLY:   hrdata <= {24'h0, dly_q};
        IDX_IRQ_STATUS: hrdata <= {29'h0, status_q};
        IDX_IRQ_MASK:   hrdata <= {29'h0, mask_q};
        default:        hrdata <= 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================
  // pin synchronisers: interrupt pins and regulator comparator
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1_q <= 3'h0;
      sync2_q <= 3'h0;
    end else if (ce) begin
      sync1_q <= {analog_regulator_output_ok, ext_irq_b_pin, ext_irq_a_pin};
      sync2_q <= sync1_q;
    end
  end

  // level recognition by programmed polarity
  assign ext_irq_a_active = (sync2_q[0] == pol_q[1]);
  assign ext_irq_b_active = (sync2_q[1] == pol_q[0]);
  assign wake = wake_irq || ext_irq_a_active || ext_irq_b_active;

  // ==========================================================
  // core power control: clock stop and idle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      core_pwr_q <= 2'h0;
    end else if (ce) begin
      if (wr_now && wr_idx_q == IDX_CORE_PWR) begin
        core_pwr_q <= {wd[CP_CLOCK_STOP], wd[CP_IDLE]};
      end else if (state_q == PMC_RUN && wake) begin
        core_pwr_q <= 2'h0;
      end
    end
  end

  // core clocks run only in normal run and only when not stopped
  assign core_clk_en   = (state_q == PMC_RUN) && (core_pwr_q == 2'h0);
  assign periph_clk_en = (state_q == PMC_RUN) && !core_pwr_q[1];

  // ==========================================================
  // polarity bits and self clearing entry strobe
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pol_q <= 2'h0;
    end else if (ce && wr_now && wr_idx_q == IDX_PD_POL) begin
      pol_q <= {wd[PP_POL_A], wd[PP_POL_B]};
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      start_q     <= 1'b0;
      start_cnt_q <= 2'h0;
    end else if (ce) begin
      if (start_wr) begin
        start_q     <= 1'b1;
        start_cnt_q <= 2'h0;
      end else if (start_q) begin
        start_cnt_q <= start_cnt_q + 2'h1;
        if (start_cnt_q == START_CYCLES - 2'h1) begin
          start_q <= 1'b0;
        end
      end
    end
  end

  // ==========================================================
  // configuration, stabilization delay and good flag
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_q <= PD_CFG_RESET;
    end else if (ce && wr_now && wr_idx_q == IDX_PD_CFG) begin
      cfg_q <= wd; // bit of the good flag is ignored on read
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dly_q <= STAB_DLY_RESET;
    end else if (ce && wr_now && wr_idx_q == IDX_STAB_DLY) begin
      dly_q <= wd;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      good_q      <= 1'b0;
      good_prev_q <= 1'b0;
    end else if (ce) begin
      good_q      <= cfg_q[PC_MON_EN] && sync2_q[2];
      good_prev_q <= good_q;
    end
  end

  // direct analog control levels
  assign analog_regulator_enable         = cfg_q[PC_AREG_EN];
  assign analog_regulator_monitor_enable = cfg_q[PC_MON_EN];
  assign sleep_counter_enable            = cfg_q[PC_SLEEP_EN];
  assign rc_osc_enable                   = cfg_q[PC_RC_EN];
  assign brownout_detector_enable        = cfg_q[PC_BOD] ~^ BOD_ONE_ENABLES;

  // ==========================================================
  // chip power mode sequencer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q   <= PMC_RUN;
      mode_q    <= MODE_NORMAL_RUN;
      dly_cnt_q <= 8'h00;
    end else if (ce) begin
      unique case (state_q)
        PMC_RUN: begin
          if (start_wr && sel_mode != MODE_NORMAL_RUN) begin
            state_q <= PMC_LOWPOWER;
            mode_q  <= sel_mode;
          end
        end
        PMC_LOWPOWER: begin
          if (wake) begin
            state_q   <= PMC_STABILIZE;
            dly_cnt_q <= dly_q;
          end
        end
        PMC_STABILIZE: begin
          if (dly_cnt_q == 8'h00) begin
            state_q <= PMC_RUN;
            mode_q  <= MODE_NORMAL_RUN;
          end else begin
            dly_cnt_q <= dly_cnt_q - 8'h01;
          end
        end
      endcase
    end
  end

  // domain levels per mode; outside low power the analog regulator and sleep timer follow their enable bits, the rest held on
  assign lowpower_active      = (state_q == PMC_LOWPOWER);
  assign digital_regulator_on = !lowpower_active || mode_q == MODE_LIGHT_SLEEP;
  assign main_osc_on          = !lowpower_active;
  assign analog_regulator_on  = !lowpower_active && cfg_q[PC_AREG_EN];
  assign sleep_timer_on       = cfg_q[PC_SLEEP_EN]
                                && (!lowpower_active || mode_q != MODE_FULL_OFF);

  // ==========================================================
  // interrupt status, set wins over write-one-to-clear
  assign event_set[IRQ_ENTRY] = start_wr && state_q == PMC_RUN && sel_mode != MODE_NORMAL_RUN;
  assign event_set[IRQ_WAKE]  = state_q == PMC_STABILIZE && dly_cnt_q == 8'h00;
  assign event_set[IRQ_GOOD]  = good_q && !good_prev_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status_q <= '0;
      mask_q   <= '0;
    end else if (ce) begin
      if (wr_now && wr_idx_q == IDX_IRQ_STATUS) begin
        status_q <= (status_q & ~wd[IRQ_BITS-1:0]) | event_set;
      end else begin
        status_q <= status_q | event_set;
      end
      if (wr_now && wr_idx_q == IDX_IRQ_MASK) begin
        mask_q <= wd[IRQ_BITS-1:0];
      end
    end
  end

  assign irq = |(status_q & mask_q);

  // ==========================================================
  // assertions
  a_strobe_two_cycles: assert property (@(posedge hclk) disable iff (!hresetn || !ce)
    $rose(start_q) && !start_wr ##1 !start_wr |-> start_q ##1 !start_q)
    else $error("entry strobe did not clear after two cycles");

  a_clock_stop_all: assert property (@(posedge hclk) disable iff (!hresetn || !ce)
    core_pwr_q[1] |-> !core_clk_en && !periph_clk_en)
    else $error("core clock still running under clock stop");

  a_idle_keeps_periph: assert property (@(posedge hclk) disable iff (!hresetn || !ce)
    core_pwr_q == 2'h1 && state_q == PMC_RUN |-> !core_clk_en && periph_clk_en)
    else $error("idle did not keep peripheral clocks only");

  a_polarity_level: assert property (@(posedge hclk) disable iff (!hresetn || !ce)
    pol_q[1] && $past(ext_irq_a_pin, 2) && $stable(pol_q) && $past(ce) && $past(ce, 2)
    |-> ext_irq_a_active)
    else $error("high polarity did not recognise high level");

  a_entry_on_strobe: assert property (@(posedge hclk) disable iff (!hresetn || !ce)
    state_q == PMC_RUN && start_wr && sel_mode != MODE_NORMAL_RUN
    |=> lowpower_active && !main_osc_on)
    else $error("strobe did not start the power mode");

  a_normal_no_entry: assert property (@(posedge hclk) disable iff (!hresetn || !ce)
    state_q == PMC_RUN && start_wr && sel_mode == MODE_NORMAL_RUN |=> state_q == PMC_RUN)
    else $error("normal mode strobe left run state");

  a_deep_sleep_domains: assert property (@(posedge hclk) disable iff (!hresetn || !ce)
    lowpower_active && mode_q == MODE_DEEP_SLEEP
    |-> !digital_regulator_on && !analog_regulator_on && sleep_timer_on == cfg_q[PC_SLEEP_EN])
    else $error("deep sleep domain levels wrong");

  a_stabilize_delay: assert property (@(posedge hclk) disable iff (!hresetn || !ce)
    lowpower_active && wake && dly_q == 8'h02
    |=> state_q == PMC_STABILIZE [*3] ##1 state_q == PMC_RUN)
    else $error("stabilization delay length wrong");

  a_good_needs_monitor: assert property (@(posedge hclk) disable iff (!hresetn || !ce)
    good_q |-> $past(cfg_q[PC_MON_EN]))
    else $error("good flag set with monitor off");

  a_wake_clears_stop: assert property (@(posedge hclk) disable iff (!hresetn || !ce)
    state_q == PMC_RUN && core_pwr_q[1] && wake && !wr_now |=> core_clk_en)
    else $error("wake did not release core clock stop");

  a_brownout_polarity: assert property (@(posedge hclk) disable iff (!hresetn)
    brownout_detector_enable == (cfg_q[PC_BOD] == BOD_ONE_ENABLES))
    else $error("brown-out control polarity wrong");

  c_enter_full_off: cover property (@(posedge hclk) disable iff (!hresetn)
    lowpower_active && mode_q == MODE_FULL_OFF);
  c_wake_to_run: cover property (@(posedge hclk) disable iff (!hresetn)
    state_q == PMC_STABILIZE ##1 state_q == PMC_RUN);
  c_irq_raised: cover property (@(posedge hclk) disable iff (!hresetn) $rose(irq));
  c_normal_strobe: cover property (@(posedge hclk) disable iff (!hresetn)
    start_wr && state_q == PMC_RUN && sel_mode == MODE_NORMAL_RUN);
  c_pin_wake: cover property (@(posedge hclk) disable iff (!hresetn)
    lowpower_active && !wake_irq && (ext_irq_a_active || ext_irq_b_active));

endmodule : pmc_power_mode_control

// File: tb/pmc_analog_model.sv
// ==========================================================
// analog regulator output comparator seen from the block
module pmc_analog_model (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic analog_regulator_enable,
  input  wire logic droop,
  output logic      analog_regulator_output_ok
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] ramp_q;
  // output ramps for four cycles after enable before it clears the threshold
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) ramp_q <= 3'h0;
    else if (!analog_regulator_enable) ramp_q <= 3'h0;
    else if (ramp_q != 3'h4) ramp_q <= ramp_q + 3'h1;
  end
  // a commanded droop pulls the output under the threshold
  assign analog_regulator_output_ok = (ramp_q == 3'h4) && !droop;
endmodule : pmc_analog_model

// File: tb/power_mode_control_test.sv
`define CHK(n, e, s) begin num_checks++; if ((e) !== (s)) begin n_mismatch++; \
  $display("Error %s exp %h got %h", n, e, s); end end
module power_mode_control_test import pmc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  localparam bit BOD = 1'b0;
  logic        hclk, hresetn, hsel, hwrite, wake_irq, pin_a, pin_b, droop, ce;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [7:0]  v;
  logic hreadyout, hresp, ext_irq_a_active, ext_irq_b_active, core_clk_en, periph_clk_en;
  logic analog_regulator_enable, analog_regulator_monitor_enable, sleep_counter_enable;
  logic rc_osc_enable, brownout_detector_enable, digital_regulator_on, main_osc_on;
  logic analog_regulator_on, sleep_timer_on, lowpower_active, irq, analog_regulator_output_ok;
  int   n_mismatch, num_checks, cyc, n;
  pmc_power_mode_control #(.BOD_ONE_ENABLES(BOD)) pmc_power_mode_control_inst (
    .hclk, .hresetn, .ce, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata, .wake_irq, .ext_irq_a_pin(pin_a),
    .ext_irq_b_pin(pin_b), .analog_regulator_output_ok, .ext_irq_a_active, .ext_irq_b_active,
    .core_clk_en, .periph_clk_en, .analog_regulator_enable, .analog_regulator_monitor_enable,
    .sleep_counter_enable, .rc_osc_enable, .brownout_detector_enable, .digital_regulator_on,
    .main_osc_on, .analog_regulator_on, .sleep_timer_on, .lowpower_active, .irq);
  pmc_analog_model pmc_analog_model_inst (
    .hclk, .hresetn, .analog_regulator_enable, .droop, .analog_regulator_output_ok);
  // ==========================================================
  // clock and hang guard
  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    cyc++;
    if (cyc > 20000) begin
      n_mismatch++;
      give_verdict();
    end
  end
  // ==========================================================
  // helpers
  function automatic logic [3:0] exp_dom(input logic [1:0] m);
    case (m)
      MODE_LIGHT_SLEEP: return 4'h9;
      MODE_DEEP_SLEEP:  return 4'h1;
      MODE_FULL_OFF:    return 4'h0;
      default:          return 4'hf;
    endcase
  endfunction : exp_dom
  // one single word transfer, read data kept in rd
  task automatic bus(input logic w, input logic [13:0] i, input logic [7:0] dat);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {16'h0, i, 2'h0};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, dat};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    #1;
  endtask : bus
  task automatic idle(input int c);
    repeat (c) @(posedge hclk);
    #1;
  endtask : idle
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : give_verdict
  // ==========================================================
  // main sequence
  initial begin
    {hresetn, hsel, hwrite, wake_irq, droop, htrans, haddr, hwdata} = '0;
    {pin_a, pin_b} = 2'h3;
    ce = 1'b1;
    void'($urandom(81));
    repeat (4) @(posedge hclk);
    `CHK("areg_rst", 1'b1, analog_regulator_enable)
    `CHK("mon_rst", 1'b1, analog_regulator_monitor_enable)
    `CHK("rc_rst", 1'b1, rc_osc_enable)
    `CHK("bod_rst", 1'b0 ~^ BOD, brownout_detector_enable)
    hresetn <= 1'b1;
    idle(1);
    bus(0, IDX_PD_CFG, 8'h0);
    `CHK("cfg_rst", PD_CFG_RESET, rd[7:0] & 8'hdf)
    bus(0, IDX_STAB_DLY, 8'h0);
    `CHK("dly_rst", STAB_DLY_RESET, rd[7:0])
    bus(1, 14'h0100, 8'hff);
    bus(0, 14'h0100, 8'h0);
    `CHK("unmapped", 32'h0, rd)
    // strobe with normal mode selected, held frozen by the clock enable
    bus(1, IDX_PD_POL, 8'h01);
    ce <= 1'b0;
    idle(3);
    `CHK("freeze_ready", 1'b0, hreadyout)
    ce <= 1'b1;
    bus(0, IDX_PD_POL, 8'h0);
    `CHK("freeze_hold", 1'b1, rd[PP_START])
    `CHK("normal_stay", 1'b0, lowpower_active)
    bus(0, IDX_PD_POL, 8'h0);
    `CHK("normal_clr", 1'b0, rd[PP_START])
    bus(1, IDX_CORE_PWR, 8'h01);
    `CHK("idle_core", 1'b0, core_clk_en)
    `CHK("idle_periph", 1'b1, periph_clk_en)
    bus(1, IDX_CORE_PWR, 8'h02);
    `CHK("stop_all", 2'h0, {core_clk_en, periph_clk_en})
    wake_irq <= 1'b1;
    idle(3);
    wake_irq <= 1'b0;
    bus(0, IDX_CORE_PWR, 8'h0);
    `CHK("wake_clear", 2'h0, rd[1:0])
    `CHK("wake_run", 1'b1, core_clk_en)
    for (int k = 0; k < 8; k++) begin
      bus(1, IDX_PD_POL, {2'h0, 2'(k), 4'h0});
      pin_a <= k[2];
      pin_b <= !k[2];
      idle(4);
      `CHK("pol_a", k[2] == k[1], ext_irq_a_active)
      `CHK("pol_b", !k[2] == k[0], ext_irq_b_active)
    end
    bus(1, IDX_PD_POL, 8'h0);
    {pin_a, pin_b} <= 2'h3;
    for (int k = 0; k < 16; k++) begin
      v = 8'($urandom) & 8'hdc;
      bus(1, IDX_PD_CFG, v);
      `CHK("areg", v[7], analog_regulator_enable)
      `CHK("mon", v[6], analog_regulator_monitor_enable)
      `CHK("sleep", v[4], sleep_counter_enable)
      `CHK("rc", v[3], rc_osc_enable)
      `CHK("bod", v[2] ~^ BOD, brownout_detector_enable)
      bus(0, IDX_PD_CFG, 8'h0);
      `CHK("cfg_rd", v, rd[7:0] & 8'hdf)
    end
    bus(1, IDX_PD_CFG, 8'h88);
    idle(10);
    bus(0, IDX_PD_CFG, 8'h0);
    `CHK("good_off", 1'b0, rd[5])
    bus(1, IDX_IRQ_STATUS, 8'h07);
    bus(1, IDX_PD_CFG, PD_CFG_RESET);
    idle(10);
    bus(0, IDX_PD_CFG, 8'h0);
    `CHK("good_on", 1'b1, rd[5])
    bus(0, IDX_IRQ_STATUS, 8'h0);
    `CHK("good_evt", 1'b1, rd[IRQ_GOOD])
    droop <= 1'b1;
    idle(10);
    bus(0, IDX_PD_CFG, 8'h0);
    `CHK("good_droop", 1'b0, rd[5])
    droop <= 1'b0;
    bus(1, IDX_IRQ_MASK, 8'h0);
    for (int m = 1; m < 4; m++) begin
      v = (m == 1) ? 8'h02 : 8'($urandom_range(30, 2));
      bus(1, IDX_STAB_DLY, v);
      bus(1, IDX_IRQ_STATUS, 8'h07);
      bus(1, IDX_PD_CFG, PD_CFG_RESET | 8'(1 << PC_SLEEP_EN) | 8'(m));
      bus(1, IDX_CORE_PWR, 8'h02);
      bus(1, IDX_PD_POL, 8'h01);
      `CHK("entered", 2'h2, {lowpower_active, core_clk_en})
      `CHK("domains", exp_dom(2'(m)), {digital_regulator_on, main_osc_on,
           analog_regulator_on, sleep_timer_on})
      idle(3);
      bus(0, IDX_PD_POL, 8'h0);
      `CHK("strobe_clr", 1'b0, rd[PP_START])
      `CHK("irq_masked", 1'b0, irq)
      pin_a <= (m != 2);
      wake_irq <= (m != 2);
      n = 0;
      while (core_clk_en !== 1'b1 && n < 400) begin
        idle(1);
        n++;
      end
      wake_irq <= 1'b0;
      pin_a <= 1'b1;
      `CHK("wake_len", int'(v) + ((m == 2) ? 5 : 3), n)
      `CHK("dom_run", 4'hf, {digital_regulator_on, main_osc_on,
           analog_regulator_on, sleep_timer_on})
      bus(0, IDX_IRQ_STATUS, 8'h0);
      `CHK("events", 2'h3, rd[1:0])
      bus(1, IDX_IRQ_MASK, 8'h03);
      `CHK("irq_on", 1'b1, irq)
      bus(1, IDX_IRQ_STATUS, 8'h03);
      `CHK("irq_clr", 1'b0, irq)
      bus(1, IDX_IRQ_MASK, 8'h0);
    end
    give_verdict();
  end
endmodule : power_mode_control_test
